// File: design/wd_pkg.sv
// Constants and types shared by the watchdog and sleep control block
package wd_pkg;
	// Clocking and time base
	localparam int CLK_HZ = 20_000_000;
	localparam int LF_OSC_HZ = 31_000;
	localparam int LF_DIV = CLK_HZ / LF_OSC_HZ;
	localparam int OST_PERIODS = 1024;
	localparam int CNT_W = 24;
	// Register indices; byte address is four times the index
	localparam logic [13:0] IDX_OPTION = 14'h0081;
	localparam logic [13:0] IDX_WDCTL = 14'h0097;
	localparam logic [13:0] IDX_SLEEPCTL = 14'h0098;
	localparam logic [13:0] IDX_STATUS = 14'h0099;
	localparam logic [13:0] IDX_ID0 = 14'h2000;
	localparam logic [13:0] IDX_CONFIG = 14'h2007;
	// Reset values
	localparam logic [7:0] WDCTL_RESET = 8'h08;
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] CONFIG_RESET = 8'hff;
	// Field positions
	localparam int WDCTL_EN_BIT = 0;
	localparam int WDCTL_PS_LSB = 1;
	localparam logic [3:0] PS_MAX = 4'hb;
	localparam logic [4:0] PS_BASE_EXP = 5'h05;
	localparam int OPT_PSA_BIT = 3;
	localparam int OPT_PS_LSB = 0;
	localparam int CFG_FOSC_LSB = 0;
	localparam int CFG_FUSE_BIT = 3;
	localparam int CFG_CP_BIT = 6;
	localparam int SC_SLEEP_BIT = 0;
	localparam int SC_CLRWD_BIT = 1;
	localparam int ST_PD_BIT = 0;
	localparam int ST_TO_BIT = 1;
	localparam int ST_SLEEP_BIT = 2;
	localparam int ST_OST_BIT = 3;
	localparam int ID_W = 7;
	// Oscillator mode codes of the clock select field
	localparam logic [2:0] FOSC_LP = 3'h0;
	localparam logic [2:0] FOSC_XT = 3'h1;
	localparam logic [2:0] FOSC_HS = 3'h2;
	// Bus codes and interrupt vector address
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	// Control states, one-hot
	typedef enum logic [2:0] {
		ST_RUN = 3'h1,
		ST_SLEEP = 3'h2,
		ST_OST = 3'h4
	} mode_t;
endpackage

// File: design/wd_count_if.sv
// Link between the sleep controller and the shared ripple counter
`timescale 1ns/10ps
`default_nettype none
interface wd_count_if;
	logic clear;
	logic run;
	logic ostStart;
	logic [4:0] periodExp;
	logic timeout;
	logic ostBusy;
	modport ctl (output clear, run, ostStart, periodExp,
		input timeout, ostBusy);
	modport counter (input clear, run, ostStart, periodExp,
		output timeout, ostBusy);
endinterface
`default_nettype wire

// File: design/wd_ripple_counter.sv
// Low-frequency time base and ripple counter shared by watchdog and start-up
`timescale 1ns/10ps
`default_nettype none
module wd_ripple_counter
	import wd_pkg::*;
#(
	parameter int DIV = LF_DIV,
	parameter int OST_COUNT = OST_PERIODS,
	parameter int W = CNT_W
) (
	input wire logic ref_clk,
	input wire logic srst,
	wd_count_if.counter cnt
);
	if (DIV < 2 || DIV > 65536 || W < 24 || OST_COUNT < 1 ||
			OST_COUNT >= (1 << W)) begin : g_chk
		$error("wd_ripple_counter: unsupported parameters");
	end

	typedef struct packed {
		logic [15:0] divCnt;
		logic [W-1:0] ripple;
		logic ostBusy;
		logic timeout;
	} cnt_t;

	cnt_t s_q, s_d;
	logic lfTick;
	logic [W-1:0] limit;

	// Counter step: start-up delay first, then watchdog counting
	always_comb begin
		s_d = s_q;
		s_d.timeout = 1'b0;
		lfTick = (s_q.divCnt == 16'(DIV - 1));
		limit = (W'(1) << cnt.periodExp) - W'(1);
		s_d.divCnt = lfTick ? 16'h0000 : s_q.divCnt + 16'h0001; // [RULE1]
		if (cnt.ostStart) begin
			s_d.ostBusy = 1'b1;
			s_d.ripple = '0;
		end else if (s_q.ostBusy) begin
			// Ripple counter lent to the start-up delay; watchdog held [RULE7]
			if (s_q.ripple == W'(OST_COUNT - 1)) begin
				s_d.ostBusy = 1'b0;
				s_d.ripple = '0;
			end else begin
				s_d.ripple = s_q.ripple + W'(1);
			end
		end else if (cnt.clear || !cnt.run) begin
			s_d.ripple = '0; // [RULE8]
		end else if (lfTick) begin
			if (s_q.ripple >= limit) begin
				s_d.timeout = 1'b1; // [RULE23]
				s_d.ripple = '0;
			end else begin
				s_d.ripple = s_q.ripple + W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cnt.timeout = s_q.timeout;
	assign cnt.ostBusy = s_q.ostBusy;
endmodule
`default_nettype wire

// File: design/watchdog_sleep_wake_control.sv
// Watchdog, sleep and wake control with its register file on AHB-Lite
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1 - Watchdog counts ticks of the 31 kHz internal oscillator only.
// RULE2 - Any reset loads watchdog_control with 0x08, about 16 ms.
// RULE3 - Programmable prescaler divides the slow clock from 32 to 65536.
// RULE4 - Period select bits 4:1 double from 1:32 to 1:65536; 1100+ reserved.
// RULE5 - Fuse set keeps watchdog running and ignores the software enable.
// RULE6 - Fuse clear: software enable bit 0 runs watchdog; resets to zero.
// RULE7 - Watchdog held in reset while start-up timer uses the counter.
// RULE8 - Watchdog cleared when off, on clear command, osc failure, wake.
// RULE9 - Waking in crystal modes keeps watchdog cleared until start-up ends.
// RULE10 - Sleep clears watchdog, clears power-down, sets timeout, freezes pins.
// RULE11 - Watchdog reset never drives the master-clear pin low.
// RULE12 - Pin reset, watchdog or enabled interrupt leave sleep.
// RULE13 - Power-down flag set at power-up; timeout flag cleared by watchdog.
// RULE14 - Enabled interrupt wakes; global enable chooses vectoring to 0004h.
// RULE15 - Sleep prefetches the instruction at the next address.
// RULE16 - Every wake-up from sleep clears the watchdog.
// RULE17 - Pending enabled interrupt turns sleep into a no-operation.
// RULE18 - Interrupt during sleep: sleep completes, then wakes at once.
// RULE19 - Only clockless peripheral sources may wake the device.
// RULE20 - Crystal wake inserts 1024 oscillator periods; none for EC or RC.
// RULE21 - Four 7-bit ID words reachable only in program/verify mode.
// RULE22 - Readout needs protection off; protection on-to-off erases memories.
// RULE23 - Watchdog timeout wakes a sleeping device, else resets it.
module watchdog_sleep_wake_control
	import wd_pkg::*;
#(
	parameter logic [7:0] WAKE_CAPABLE = 8'hff,
	parameter int OST_COUNT = OST_PERIODS
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic masterClearPin_n,
	input wire logic progMode,
	input wire logic oscFail,
	input wire logic [7:0] irqFlags,
	input wire logic [7:0] irqEnables,
	input wire logic globalIrqEnable,
	output logic wdReset,
	output logic sleeping,
	output logic oscDriverOn,
	output logic ioFreeze,
	output logic prefetchNext,
	output logic wakeResume,
	output logic vectorJump,
	output logic [12:0] vectorAddr,
	output logic memEraseAll,
	output logic progReadAllowed,
	output logic masterClearOut,
	output logic masterClearOe
);
	if (WAKE_CAPABLE == 8'h00 || OST_COUNT < 1) begin : g_chk
		$error("watchdog_sleep_wake_control: unsupported parameters");
	end

	typedef struct packed {
		logic [2:0] syncMeta;
		logic [2:0] syncOut;
		mode_t mode;
		logic [7:0] optionReg;
		logic [7:0] wdCtl;
		logic [7:0] configReg;
		logic [3:0][ID_W-1:0] ids;
		logic powerdownFlag_n;
		logic timeoutFlag_n;
		logic wakeByIrq;
		logic apValid;
		logic apWrite;
		logic [13:0] apIdx;
		logic [31:0] rdata;
		logic readyOut;
		logic resp;
		logic wdClear;
		logic wdRun;
		logic ostStart;
		logic wdReset;
		logic sleeping;
		logic oscDriverOn;
		logic ioFreeze;
		logic prefetchNext;
		logic wakeResume;
		logic vectorJump;
		logic memEraseAll;
		logic progReadAllowed;
		logic mclrOut;
		logic mclrOe;
	} core_t;

	localparam core_t CORE_RESET = '{
		syncMeta: 3'h1,
		syncOut: 3'h1,
		mode: ST_RUN,
		optionReg: OPTION_RESET,
		wdCtl: WDCTL_RESET,
		configReg: CONFIG_RESET,
		ids: '0,
		powerdownFlag_n: 1'b1,
		timeoutFlag_n: 1'b1,
		wakeByIrq: 1'b0,
		apValid: 1'b0,
		apWrite: 1'b0,
		apIdx: 14'h0000,
		rdata: 32'h0000_0000,
		readyOut: 1'b1,
		resp: HRESP_OKAY,
		wdClear: 1'b1,
		wdRun: 1'b1,
		ostStart: 1'b0,
		wdReset: 1'b0,
		sleeping: 1'b0,
		oscDriverOn: 1'b1,
		ioFreeze: 1'b0,
		prefetchNext: 1'b0,
		wakeResume: 1'b0,
		vectorJump: 1'b0,
		memEraseAll: 1'b0,
		progReadAllowed: 1'b1,
		mclrOut: 1'b0,
		mclrOe: 1'b1
	};

	core_t s_q, s_d;
	wd_count_if cnt ();

	logic mclrLow;
	logic inProg;
	logic oscFailSeen;
	logic fuseOn;
	logic crystal;
	logic irqPending;
	logic irqWake;
	logic sleepCmd;
	logic clrwdCmd;
	logic wake;
	logic [3:0] periodSel;
	logic [13:0] rdIdx;

	// Register read mux; reserved and unmapped words read as zero
	function automatic logic [31:0] readReg(core_t t, logic [13:0] idx,
			logic prog, logic ostBusy);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (idx)
			IDX_OPTION: r = {24'h000000, t.optionReg};
			IDX_WDCTL: r = {27'h0000000, t.wdCtl[4:0]};
			IDX_CONFIG: r = {24'h000000, t.configReg};
			IDX_STATUS: begin
				r[ST_PD_BIT] = t.powerdownFlag_n;
				r[ST_TO_BIT] = t.timeoutFlag_n;
				r[ST_SLEEP_BIT] = t.sleeping;
				r[ST_OST_BIT] = ostBusy;
			end
			default: begin
				if (prog && idx[13:2] == IDX_ID0[13:2]) begin
					r = {25'h0000000, t.ids[idx[1:0]]}; // [RULE21]
				end
			end
		endcase
		return r;
	endfunction

	// Next-state logic: sync, bus, commands, sleep and wake
	always_comb begin
		s_d = s_q;
		s_d.wdReset = 1'b0;
		s_d.prefetchNext = 1'b0;
		s_d.wakeResume = 1'b0;
		s_d.vectorJump = 1'b0;
		s_d.memEraseAll = 1'b0;
		s_d.ostStart = 1'b0;
		s_d.readyOut = 1'b1;
		s_d.resp = HRESP_OKAY;

		// Pin inputs through two flip-flops
		s_d.syncMeta = {oscFail, progMode, masterClearPin_n};
		s_d.syncOut = s_q.syncMeta;
		mclrLow = !s_q.syncOut[0];
		inProg = s_q.syncOut[1];
		oscFailSeen = s_q.syncOut[2];

		fuseOn = s_q.configReg[CFG_FUSE_BIT];
		crystal = s_q.configReg[CFG_FOSC_LSB +: 3] inside
			{FOSC_LP, FOSC_XT, FOSC_HS};
		irqPending = |(irqFlags & irqEnables); // [RULE14]
		irqWake = |(irqFlags & irqEnables & WAKE_CAPABLE); // [RULE19]
		sleepCmd = 1'b0;
		clrwdCmd = 1'b0;
		wake = 1'b0;

		// Address phase capture
		if (hready) begin
			s_d.apValid = hsel && htrans == HTRANS_NONSEQ;
			s_d.apWrite = hwrite;
			s_d.apIdx = haddr[15:2];
		end

		// Data phase write
		if (s_q.apValid && s_q.apWrite) begin
			case (s_q.apIdx)
				IDX_OPTION: s_d.optionReg = hwdata[7:0];
				IDX_WDCTL: s_d.wdCtl = {3'h0, hwdata[4:0]};
				IDX_CONFIG: begin
					s_d.configReg = hwdata[7:0];
					if (!s_q.configReg[CFG_CP_BIT] && hwdata[CFG_CP_BIT]) begin
						s_d.memEraseAll = 1'b1; // [RULE22]
					end
				end
				IDX_SLEEPCTL: begin
					sleepCmd = hwdata[SC_SLEEP_BIT];
					clrwdCmd = hwdata[SC_CLRWD_BIT];
				end
				default: begin
					if (inProg && s_q.apIdx[13:2] == IDX_ID0[13:2]) begin
						s_d.ids[s_q.apIdx[1:0]] = hwdata[ID_W-1:0]; // [RULE21]
					end
				end
			endcase
		end

		// Control state machine
		case (s_q.mode)
			ST_RUN: begin
				if (cnt.timeout) begin
					s_d.wdReset = 1'b1; // [RULE23]
					s_d.timeoutFlag_n = 1'b0; // [RULE13]
				end else if (sleepCmd && !irqPending) begin
					// Sleep completes; a pending source makes it a no-op [RULE17]
					s_d.mode = ST_SLEEP;
					s_d.powerdownFlag_n = 1'b0; // [RULE10] [RULE13]
					s_d.timeoutFlag_n = 1'b1; // [RULE10]
					s_d.sleeping = 1'b1;
					s_d.oscDriverOn = 1'b0; // [RULE10]
					s_d.ioFreeze = 1'b1; // [RULE10]
					s_d.prefetchNext = 1'b1; // [RULE15]
					clrwdCmd = 1'b1; // [RULE10]
				end
			end
			ST_SLEEP: begin
				if (cnt.timeout) begin
					wake = 1'b1; // [RULE12] [RULE23]
					s_d.timeoutFlag_n = 1'b0; // [RULE13]
					s_d.wakeByIrq = 1'b0;
				end else if (irqWake) begin
					wake = 1'b1; // [RULE12] [RULE18]
					s_d.wakeByIrq = 1'b1;
				end
				if (wake) begin
					s_d.sleeping = 1'b0;
					s_d.oscDriverOn = 1'b1;
					s_d.ioFreeze = 1'b0;
					if (crystal) begin
						s_d.mode = ST_OST; // [RULE9] [RULE20]
						s_d.ostStart = 1'b1;
					end else begin
						s_d.mode = ST_RUN; // [RULE20]
						s_d.wakeResume = 1'b1;
						s_d.vectorJump = irqWake && !cnt.timeout &&
							globalIrqEnable; // [RULE14]
					end
				end
			end
			ST_OST: begin
				// Watchdog stays cleared until start-up delay ends [RULE9]
				if (!s_q.ostStart && !cnt.ostBusy) begin
					s_d.mode = ST_RUN;
					s_d.wakeResume = 1'b1;
					s_d.vectorJump = s_q.wakeByIrq && globalIrqEnable; // [RULE14]
				end
			end
			default: s_d.mode = ST_RUN;
		endcase

		// Watchdog enable: fuse overrides software bit
		s_d.wdRun = fuseOn || s_d.wdCtl[WDCTL_EN_BIT]; // [RULE5] [RULE6]
		s_d.wdClear = !s_d.wdRun || clrwdCmd || oscFailSeen || wake ||
			s_d.mode == ST_OST; // [RULE8] [RULE16] [RULE9]

		// Pin or watchdog reset reloads control registers
		if (mclrLow || s_d.wdReset) begin
			s_d.optionReg = OPTION_RESET;
			s_d.wdCtl = WDCTL_RESET; // [RULE2]
			s_d.wdRun = fuseOn;
			s_d.wdClear = 1'b1;
			s_d.mode = ST_RUN;
			s_d.sleeping = 1'b0;
			s_d.oscDriverOn = 1'b1;
			s_d.ioFreeze = 1'b0;
			s_d.wakeResume = 1'b0;
			s_d.vectorJump = 1'b0;
			s_d.ostStart = 1'b0;
			s_d.wakeByIrq = 1'b0;
		end
		if (mclrLow) begin
			s_d.wdReset = 1'b0; // [RULE12]
		end

		// Master-clear pin is never driven by this block
		s_d.mclrOut = 1'b0;
		s_d.mclrOe = 1'b1; // [RULE11]
		s_d.progReadAllowed = s_d.configReg[CFG_CP_BIT]; // [RULE22]

		// Read data for the coming data phase, after any write
		rdIdx = haddr[15:2];
		if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
			s_d.rdata = readReg(s_d, rdIdx, inProg, cnt.ostBusy);
		end else begin
			s_d.rdata = 32'h0000_0000;
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= CORE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Period exponent: prescaler plus optional postscaler [RULE3] [RULE4]
	always_comb begin
		periodSel = s_q.wdCtl[WDCTL_PS_LSB +: 4];
		if (periodSel > PS_MAX) begin
			periodSel = PS_MAX; // Reserved codes act as longest period
		end
		cnt.periodExp = PS_BASE_EXP + {1'b0, periodSel} +
			(s_q.optionReg[OPT_PSA_BIT] ?
			{2'h0, s_q.optionReg[OPT_PS_LSB +: 3]} : 5'h00);
	end

	// Counter control from registered state
	assign cnt.clear = s_q.wdClear;
	assign cnt.run = s_q.wdRun;
	assign cnt.ostStart = s_q.ostStart;

	wd_ripple_counter #(
		.DIV(LF_DIV),
		.OST_COUNT(OST_COUNT),
		.W(CNT_W)
	) u_counter (
		.ref_clk(ref_clk),
		.srst(srst),
		.cnt(cnt.counter)
	);

	// Outputs straight from state flops; vectorAddr is the constant IRQ_VECTOR
	assign hreadyout = s_q.readyOut;
	assign hresp = s_q.resp;
	assign hrdata = s_q.rdata;
	assign wdReset = s_q.wdReset;
	assign sleeping = s_q.sleeping;
	assign oscDriverOn = s_q.oscDriverOn;
	assign ioFreeze = s_q.ioFreeze;
	assign prefetchNext = s_q.prefetchNext;
	assign wakeResume = s_q.wakeResume;
	assign vectorJump = s_q.vectorJump;
	assign vectorAddr = IRQ_VECTOR;
	assign memEraseAll = s_q.memEraseAll;
	assign progReadAllowed = s_q.progReadAllowed;
	assign masterClearOut = s_q.mclrOut;
	assign masterClearOe = s_q.mclrOe;
endmodule
`default_nettype wire

// File: sim/wd_checker_asserts.sv
// Port-level checks on the watchdog sleep and wake block
`timescale 1ns/10ps
`default_nettype none
module wd_checker
	import wd_pkg::*;
#(
	parameter int OST_COUNT = OST_PERIODS
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic wdReset,
	input wire logic sleeping,
	input wire logic oscDriverOn,
	input wire logic ioFreeze,
	input wire logic prefetchNext,
	input wire logic wakeResume,
	input wire logic vectorJump,
	input wire logic [12:0] vectorAddr,
	input wire logic masterClearOe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// Pin never driven, pins frozen only asleep
	property p_master_clear_pin;
		masterClearOe;
	endproperty
	a_master_clear_pin: assert property (p_master_clear_pin)
		else $error("master clear pin driven");
	property p_pins;
		ioFreeze == sleeping && oscDriverOn == !sleeping;
	endproperty
	a_pins: assert property (p_pins)
		else $error("sleep outputs disagree");
	// Prefetch pulse marks the start of sleep
	property p_pre;
		prefetchNext == $rose(sleeping);
	endproperty
	a_pre: assert property (p_pre)
		else $error("prefetch not with sleep entry");
	// Vectoring only as part of a resume
	property p_vec;
		vectorJump |-> wakeResume;
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector without resume");
	property p_addr;
		vectorAddr == 13'h0004;
	endproperty
	a_addr: assert property (p_addr)
		else $error("vector address wrong");
	// Timeout resets only when awake, as a pulse
	property p_wdr;
		wdReset |-> !sleeping ##1 !wdReset;
	endproperty
	a_wdr: assert property (p_wdr)
		else $error("watchdog reset misbehaves");
	property p_wake;
		$fell(sleeping) |-> !wdReset;
	endproperty
	a_wake: assert property (p_wake)
		else $error("reset instead of wake");
	property p_res;
		wakeResume |-> !sleeping && oscDriverOn;
	endproperty
	a_res: assert property (p_res)
		else $error("resume while asleep");
	// Main scenarios reached
	c_vec: cover property (wakeResume && vectorJump);
	c_wdr: cover property (wdReset);
	c_pre: cover property (prefetchNext);
endmodule
`default_nettype wire

// File: sim/test_watchdog_sleep_wake_control.sv
// Self-checking bench for the watchdog sleep and wake block
`timescale 1ns/10ps
`default_nettype none
module test_watchdog_sleep_wake_control
	import wd_pkg::*;
;
	localparam int OST_N = 64;
	logic ref_clk, srst, hsel, hwrite, progMode, global_irq_enable, clrPin_n;
	logic hreadyout, hresp, wdReset, sleeping, oscDriverOn, ioFreeze;
	logic prefetchNext, wakeResume, vectorJump, memEraseAll;
	logic progReadAllowed, masterClearOut, masterClearOe;
	logic [1:0] htrans;
	logic [7:0] irqFlags, irqEnables;
	logic [12:0] vectorAddr;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int errTotal, testsRun, n;

	watchdog_sleep_wake_control #(.OST_COUNT(OST_N)) dut_u (
		.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .masterClearPin_n(clrPin_n), .progMode(progMode),
		.oscFail(1'b0), .irqFlags(irqFlags), .irqEnables(irqEnables),
		.globalIrqEnable(global_irq_enable), .wdReset(wdReset), .sleeping(sleeping),
		.oscDriverOn(oscDriverOn), .ioFreeze(ioFreeze),
		.prefetchNext(prefetchNext), .wakeResume(wakeResume),
		.vectorJump(vectorJump), .vectorAddr(vectorAddr),
		.memEraseAll(memEraseAll), .progReadAllowed(progReadAllowed),
		.masterClearOut(masterClearOut), .masterClearOe(masterClearOe));

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask

	// Edges until the slave is ready; only the hang guard ends a stall
	task automatic rdy();
		do begin
			@(posedge ref_clk);
		end while (hreadyout !== 1'b1);
	endtask

	// One word transfer; read data left in rd
	task automatic bus(input logic wr, input logic [13:0] idx,
			input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {16'h0000, idx, 2'b00};
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask

	task automatic rc(input logic [13:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(rd, exp);
		chk(hresp, 32'(HRESP_OKAY));
	endtask

	// Wait for resume (sel 1) or timeout reset (sel 0)
	task automatic waitFor(input bit sel, input int lim);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while ((sel ? wakeResume : wdReset) !== 1'b1 && n < lim);
	endtask

	task automatic tRegs();
		rc(IDX_WDCTL, 32'h08);
		rc(IDX_STATUS, 32'h03);
		bus(1'b1, IDX_WDCTL, 32'hff);
		rc(IDX_WDCTL, 32'h1f);
		bus(1'b1, IDX_ID0, 32'hff);
		rc(IDX_ID0, 32'h00);
		progMode <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bus(1'b1, IDX_ID0 + 14'h3, 32'hff);
		rc(IDX_ID0 + 14'h3, 32'h7f);
		progMode <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rc(IDX_ID0 + 14'h3, 32'h0);
		rc(14'h0100, 32'h0);
	endtask

	task automatic tNoop();
		irqEnables <= 8'h01;
		irqFlags <= 8'h01;
		@(posedge ref_clk);
		bus(1'b1, IDX_SLEEPCTL, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk(sleeping, 1'b0);
		rc(IDX_STATUS, 32'h03);
		irqFlags <= 8'h00;
	endtask

	task automatic tIrqWake();
		global_irq_enable <= 1'b1;
		bus(1'b1, IDX_SLEEPCTL, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk({ioFreeze, oscDriverOn, sleeping}, 3'b101);
		rc(IDX_STATUS, 32'h06);
		irqFlags <= 8'h01;
		waitFor(1'b1, 20);
		chk(vectorJump, 1'b1);
		chk(n < 6, 1'b1);
		irqFlags <= 8'h00;
		global_irq_enable <= 1'b0;
	endtask

	task automatic tCrystal();
		bus(1'b1, IDX_CONFIG, 32'h01);
		repeat (2) @(posedge ref_clk);
		chk(progReadAllowed, 1'b0);
		bus(1'b1, IDX_CONFIG, 32'h41);
		n = 0;
		repeat (3) begin
			@(posedge ref_clk);
			if (memEraseAll === 1'b1) n++;
		end
		chk(n, 1);
		chk(progReadAllowed, 1'b1);
		bus(1'b1, IDX_SLEEPCTL, 32'h1);
		repeat (3) @(posedge ref_clk);
		irqFlags <= 8'h01;
		waitFor(1'b1, 4 * OST_N);
		chk(n >= OST_N && n < 4 * OST_N, 1'b1);
		chk(vectorJump, 1'b0);
		irqFlags <= 8'h00;
	endtask

	// Shortest period: 32 slow ticks of 645 cycles
	task automatic tWdog();
		bus(1'b1, IDX_CONFIG, 32'h4c);
		bus(1'b1, IDX_OPTION, 32'h00);
		bus(1'b1, IDX_WDCTL, 32'h00);
		repeat (15000) @(posedge ref_clk);
		bus(1'b1, IDX_SLEEPCTL, 32'h2);
		waitFor(1'b0, 30000);
		chk(n > 19000 && n < 22000, 1'b1);
		chk({masterClearOut, masterClearOe}, 32'h1);
		repeat (3) @(posedge ref_clk);
		rc(IDX_STATUS, 32'h00);
		rc(IDX_WDCTL, 32'h08);
		bus(1'b1, IDX_OPTION, 32'h00);
		bus(1'b1, IDX_WDCTL, 32'h00);
		bus(1'b1, IDX_SLEEPCTL, 32'h1);
		repeat (3) @(posedge ref_clk);
		rc(IDX_STATUS, 32'h06);
		waitFor(1'b1, 30000);
		chk(n > 19000 && n < 22000, 1'b1);
		rc(IDX_STATUS, 32'h00);
	endtask

	// Pin reset while asleep leaves sleep and reloads control
	task automatic tPin();
		bus(1'b1, IDX_SLEEPCTL, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk(sleeping, 1'b1);
		clrPin_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk({sleeping, wakeResume, wdReset}, 3'b000);
		clrPin_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rc(IDX_WDCTL, 32'h08);
		rc(IDX_STATUS, 32'h02);
	endtask

	// Main sequence
	initial begin
		srst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		progMode = 1'b0;
		clrPin_n = 1'b1;
		global_irq_enable = 1'b0;
		irqFlags = 8'h00;
		irqEnables = 8'h00;
		errTotal = 0;
		testsRun = 0;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		tRegs();
		tNoop();
		tIrqWake();
		tCrystal();
		tWdog();
		tPin();
		conclude();
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge ref_clk);
		errTotal++;
		conclude();
	end
endmodule

bind watchdog_sleep_wake_control wd_checker #(.OST_COUNT(OST_COUNT)) chkU (
	.ref_clk(ref_clk), .srst(srst), .wdReset(wdReset),
	.sleeping(sleeping), .oscDriverOn(oscDriverOn), .ioFreeze(ioFreeze),
	.prefetchNext(prefetchNext), .wakeResume(wakeResume),
	.vectorJump(vectorJump), .vectorAddr(vectorAddr),
	.masterClearOe(masterClearOe));
`default_nettype wire
